//--- rtl/abr_top.sv
// How it works
// R1: Read opcode returns word, low byte first
// R2: Read repeats every 32 bits while selected
// R3: Write accepted only with enable latch set
// R4: Write opcode then 32 bits, low byte first
// R5: Frame must end exactly after bit 32
// R6: Write cycle starts at chip enable rise
// R7: Busy bit high during cycle, status readable
// R8: Enable latch cleared when cycle ends
// R9: Boot word holds address, delay, enable
// R10: Quad mode moves four bits per clock
module abr_top
  import abr_pkg::*;
#(
  parameter int WRITE_CYCLES = ABR_WRITE_CYCLES
) (
  // System
  input  wire logic        CLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Serial link
  input  wire logic        SCK,
  input  wire logic        CE_N,
  input  wire logic [3:0]  IO_IN,
  output logic      [3:0]  IO_OUT,
  output logic      [3:0]  IO_OE,
  // Boot configuration
  output logic      [23:0] BOOT_START_ADDR,
  output logic      [3:0]  BOOT_START_DELAY,
  output logic             BOOT_FEATURE_ENABLE
);

  // Link word order is low byte first, high bit of each byte first
  function automatic logic [31:0] byte_swap(input logic [31:0] w);
    byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Core state
  logic [31:0] boot_reg;
  logic [31:0] boot_next;
  logic        wel_reg;
  logic        wel_next;
  logic [1:0]  ctrl_reg;
  abr_core_t   core_reg;
  abr_core_t   core_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic        arm_pend_reg;
  logic        write_enable_cmd_pend_reg;
  logic        ce_n_prev_reg;
  logic [31:0] wr_data_reg;

  wire quad_lines_enable = ctrl_reg[ABR_CTRL_QE_BIT];
  wire qpi_mode          = ctrl_reg[ABR_CTRL_QPI_BIT];
  wire write_in_progress = (core_reg == ABR_CORE_WRITE);
  wire [7:0] status_byte = {1'b0, quad_lines_enable, 4'h0, wel_reg, write_in_progress};

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link domain; all but the hold word and event toggles cleared whenever chip enable is high
  abr_link_t   lk_state_reg;
  logic [6:0]  lk_cnt_reg;
  logic [7:0]  lk_op_reg;
  logic [31:0] lk_sh_reg;
  logic [31:0] lk_tx_reg;
  logic        lk_done_reg;
  logic [31:0] lk_hold_reg;
  logic        lk_arm_tgl_reg;
  logic        lk_cancel_tgl_reg;
  logic        lk_write_enable_cmd_tgl_reg;
  logic [4:0]  lk_ptr_reg;

  wire [6:0]  lk_step   = qpi_mode ? 7'd4 : 7'd1;
  wire [6:0]  lk_cnt_nx = lk_cnt_reg + lk_step;
  // R10: nibble per clock
  wire [7:0]  lk_op_nx  = qpi_mode ? {lk_op_reg[3:0], IO_IN} : {lk_op_reg[6:0], IO_IN[0]};
  wire [31:0] lk_sh_nx  = qpi_mode ? {lk_sh_reg[27:0], IO_IN} : {lk_sh_reg[30:0], IO_IN[0]};
  wire        lk_op_end = (lk_state_reg == ABR_LK_OPCODE) && (lk_cnt_nx == 7'd8);
  // R5: exactly 32 data bits
  wire        lk_wr_end = (lk_state_reg == ABR_LK_WRITE) && (lk_cnt_nx == 7'd40);
  wire        lk_wr_over = (lk_state_reg == ABR_LK_WRITE) && lk_done_reg;

  // Status and boot word are quasi-static while a frame is being clocked
  always_ff @(posedge SCK or posedge CE_N) begin
    if (CE_N) begin
      lk_state_reg <= ABR_LK_OPCODE;
      lk_cnt_reg   <= 7'd0;
      lk_op_reg    <= 8'h00;
      lk_sh_reg    <= 32'h0000_0000;
      lk_tx_reg    <= 32'h0000_0000;
      lk_done_reg  <= 1'b0;
    end else begin
      lk_cnt_reg <= (lk_cnt_reg >= 7'd40) ? lk_cnt_reg : lk_cnt_nx;
      lk_op_reg  <= (lk_state_reg == ABR_LK_OPCODE) ? lk_op_nx : lk_op_reg;
      lk_sh_reg  <= lk_sh_nx;
      if (lk_wr_end) begin
        lk_done_reg <= 1'b1;
      end
      if (lk_op_end) begin
        case (lk_op_nx)
          // R1: load word for readout
          ABR_OP_BOOT_READ: begin
            lk_state_reg <= ABR_LK_READ;
            lk_tx_reg    <= byte_swap(boot_reg);
          end
          ABR_OP_STATUS_READ: begin
            lk_state_reg <= ABR_LK_STATUS;
            lk_tx_reg    <= {4{status_byte}};
          end
          ABR_OP_BOOT_WRITE: begin
            lk_state_reg <= ABR_LK_WRITE;
          end
          default: begin
            lk_state_reg <= ABR_LK_IGNORE;
          end
        endcase
      end
    end
  end

  // Events that must outlive the frame, so they are not cleared by chip enable
  always_ff @(posedge SCK or posedge RESET) begin
    if (RESET) begin
      lk_arm_tgl_reg    <= 1'b0;
      lk_cancel_tgl_reg <= 1'b0;
      lk_write_enable_cmd_tgl_reg   <= 1'b0;
      lk_hold_reg       <= 32'h0000_0000;
    end else if (!CE_N) begin
      // R4: capture data word
      if (lk_wr_end) begin
        lk_hold_reg    <= byte_swap(lk_sh_nx);
        lk_arm_tgl_reg <= ~lk_arm_tgl_reg;
      end
      // R5: extra bit cancels
      if (lk_wr_over) begin
        lk_cancel_tgl_reg <= ~lk_cancel_tgl_reg;
      end
      if (lk_op_end && (lk_op_nx == ABR_OP_WRITE_ENABLE)) begin
        lk_write_enable_cmd_tgl_reg <= ~lk_write_enable_cmd_tgl_reg;
      end
    end
  end

  // Output side shifts on the falling edge
  wire        lk_reading = (lk_state_reg == ABR_LK_READ) || (lk_state_reg == ABR_LK_STATUS);
  wire [31:0] lk_tx_sh   = lk_tx_reg << lk_ptr_reg;

  always_ff @(negedge SCK or posedge CE_N) begin
    if (CE_N) begin
      lk_ptr_reg <= 5'd0;
      IO_OUT     <= 4'h0;
      IO_OE      <= 4'h0;
    end else if (lk_reading) begin
      // R2: pointer wraps at 32
      lk_ptr_reg <= lk_ptr_reg + lk_step[4:0];
      // R10: four lines in quad mode
      IO_OUT     <= qpi_mode ? lk_tx_sh[31:28] : {2'b00, lk_tx_sh[31], 1'b0};
      IO_OE      <= qpi_mode ? 4'hf : 4'h2;
    end else begin
      IO_OE      <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Crossing into the core clock
  logic [3:0] sync_q;
  logic [3:0] sync_prev_reg;

  abr_sync #(.W(4)) u_sync (
    .clk (CLK),
    .d   ({CE_N, lk_write_enable_cmd_tgl_reg, lk_cancel_tgl_reg, lk_arm_tgl_reg}),
    .q   (sync_q)
  );

  wire ce_rise    = sync_q[3] && !ce_n_prev_reg;
  wire write_enable_cmd_evt   = sync_q[2] ^ sync_prev_reg[2];
  wire cancel_evt = sync_q[1] ^ sync_prev_reg[1];
  wire arm_evt    = sync_q[0] ^ sync_prev_reg[0];
  // R3: write needs latch
  wire start_wr   = ce_rise && (arm_pend_reg || arm_evt) && !cancel_evt && wel_reg
                    && !write_in_progress;
  wire timer_end  = write_in_progress && (timer_reg == 32'd0);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Write cycle control
  always_comb begin
    core_next  = core_reg;
    timer_next = timer_reg;
    boot_next  = boot_reg;
    wel_next   = wel_reg;
    if (ce_rise && (write_enable_cmd_pend_reg || write_enable_cmd_evt) && !write_in_progress) begin
      wel_next = 1'b1;
    end
    case (core_reg)
      ABR_CORE_IDLE: begin
        // R6: start at frame end
        if (start_wr) begin
          core_next  = ABR_CORE_WRITE;
          timer_next = 32'(WRITE_CYCLES - 1);
        end
      end
      default: begin
        // R7: busy until timer done
        if (timer_end) begin
          core_next = ABR_CORE_IDLE;
          boot_next = wr_data_reg;
          // R8: latch cleared
          wel_next  = 1'b0;
        end else begin
          timer_next = timer_reg - 32'd1;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      core_reg      <= ABR_CORE_IDLE;
      timer_reg     <= 32'd0;
      boot_reg      <= ABR_BOOT_RESET;
      wel_reg       <= 1'b0;
      arm_pend_reg  <= 1'b0;
      write_enable_cmd_pend_reg <= 1'b0;
      ce_n_prev_reg <= 1'b1;
      sync_prev_reg <= 4'h0;
      wr_data_reg   <= 32'h0000_0000;
    end else begin
      core_reg      <= core_next;
      timer_reg     <= timer_next;
      boot_reg      <= boot_next;
      wel_reg       <= wel_next;
      ce_n_prev_reg <= sync_q[3];
      sync_prev_reg <= sync_q;
      // Word taken at start, so a frame sent while busy cannot alter it
      wr_data_reg   <= start_wr ? lk_hold_reg : wr_data_reg;
      // R5: cancel beats arm, it always follows it
      arm_pend_reg  <= ce_rise ? 1'b0 : (cancel_evt ? 1'b0 : (arm_evt ? 1'b1 : arm_pend_reg));
      write_enable_cmd_pend_reg <= ce_rise ? 1'b0 : (write_enable_cmd_evt ? 1'b1 : write_enable_cmd_pend_reg);
    end
  end

  // R9: boot word fields
  assign BOOT_START_ADDR     = boot_reg[ABR_BOOT_ADDR_LSB +: 24];
  assign BOOT_START_DELAY    = boot_reg[ABR_BOOT_DLY_LSB +: ABR_BOOT_DLY_W];
  assign BOOT_FEATURE_ENABLE = boot_reg[ABR_BOOT_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  wire apb_access = PSEL && PENABLE;
  wire hit_status = (PADDR == ABR_OFS_STATUS);
  wire hit_ctrl   = (PADDR == ABR_OFS_CTRL);
  wire hit_boot   = (PADDR == ABR_OFS_BOOT);
  wire apb_hit    = hit_status || hit_ctrl || hit_boot;
  wire [31:0] apb_rdata = hit_status ? {24'h000000, status_byte}
                        : hit_ctrl   ? {30'h0, ctrl_reg}
                        : hit_boot   ? boot_reg
                        : 32'h0000_0000;

  assign PREADY  = 1'b1;
  assign PSLVERR = apb_access && !apb_hit;

  // Control changes reach the link at once, even mid-frame; change them only while idle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= ABR_CTRL_RESET;
      PRDATA   <= 32'h0000_0000;
    end else begin
      if (apb_access && PWRITE && hit_ctrl) begin
        ctrl_reg <= PWDATA[1:0];
      end
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= apb_rdata;
      end
    end
  end

endmodule

//--- rtl/abr_pkg.sv
package abr_pkg;
  // Link opcodes
  localparam logic [7:0]  ABR_OP_BOOT_READ    = 8'h14;
  localparam logic [7:0]  ABR_OP_BOOT_WRITE   = 8'h15;
  localparam logic [7:0]  ABR_OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0]  ABR_OP_STATUS_READ  = 8'h05;
  // APB byte offsets
  localparam logic [11:0] ABR_OFS_STATUS      = 12'h000;
  localparam logic [11:0] ABR_OFS_CTRL        = 12'h004;
  localparam logic [11:0] ABR_OFS_BOOT        = 12'h008;
  // Status fields, same layout on APB and on the link
  localparam int          ABR_ST_WIP_BIT      = 0;
  localparam int          ABR_ST_WEL_BIT      = 1;
  localparam int          ABR_ST_QE_BIT       = 6;
  // Control fields
  localparam int          ABR_CTRL_QE_BIT     = 0;
  localparam int          ABR_CTRL_QPI_BIT    = 1;
  // Boot register fields
  localparam int          ABR_BOOT_EN_BIT     = 0;
  localparam int          ABR_BOOT_DLY_LSB    = 1;
  localparam int          ABR_BOOT_DLY_W      = 4;
  localparam int          ABR_BOOT_ADDR_LSB   = 8;
  localparam int          ABR_BOOT_W          = 32;
  // Reset values
  localparam logic [31:0] ABR_BOOT_RESET      = 32'h0000_0000;
  localparam logic [1:0]  ABR_CTRL_RESET      = 2'h0;
  // Write cycle time
  localparam int          ABR_CLK_MHZ         = 200;
  localparam int          ABR_WRITE_TIME_NS   = 10000;
  localparam int          ABR_WRITE_CYCLES    = (ABR_WRITE_TIME_NS * ABR_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ABR_LK_OPCODE = 3'b000,
    ABR_LK_READ   = 3'b001,
    ABR_LK_STATUS = 3'b010,
    ABR_LK_WRITE  = 3'b011,
    ABR_LK_IGNORE = 3'b100
  } abr_link_t;

  typedef enum logic {
    ABR_CORE_IDLE  = 1'b0,
    ABR_CORE_WRITE = 1'b1
  } abr_core_t;
endpackage

//--- rtl/abr_sync.sv
module abr_sync #(
  parameter int W = 1
) (
  // Clock and data
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end
endmodule

//--- test/abr_host.sv
module abr_host (
  // Link
  output logic            sck,
  output logic            ce_n,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Applied once the design waits, so chip enable high clears the link
  initial begin
    sck <= 1'b0;
    ce_n <= 1'b1;
    io_in <= 4'h0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic frame(input bit q, input logic [7:0] op, input logic [31:0] w,
                       input int nb, output logic [63:0] got);
    logic [71:0] s;
    s = {op, w[7:0], w[15:8], w[23:16], w[31:24], 32'h0};
    got = 64'h0;
    ce_n = 1'b0;
    #3.1;
    for (int i = 0; i < 8 + nb; i += (q ? 4 : 1)) begin
      io_in = q ? s[71-i -: 4] : {~io_in[3:1], s[71-i]};
      #3.6 sck = 1'b1;
      if (i >= 8)
        got = q ? {got[59:0], io_out} : {got[62:0], io_out[1]};
      #7.5 sck = 1'b0;
      #3.9;
    end
    // Released lines flip so stale data never looks valid
    ce_n = 1'b1;
    io_in = ~io_in;
  endtask
endmodule

//--- test/abr_top_assertions.sv
module abr_checker
  import abr_pkg::*;
#(
  parameter int WRITE_CYCLES = ABR_WRITE_CYCLES
) (
  // System and bus
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Link and boot word
  input wire logic        CE_N,
  input wire logic [3:0]  IO_OE,
  input wire logic [23:0] BOOT_START_ADDR,
  input wire logic [3:0]  BOOT_START_DELAY,
  input wire logic        BOOT_FEATURE_ENABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  wire logic [28:0] boot_w = {BOOT_START_ADDR, BOOT_START_DELAY, BOOT_FEATURE_ENABLE};
  wire logic mapped = PADDR inside {ABR_OFS_STATUS, ABR_OFS_CTRL, ABR_OFS_BOOT};
  wire logic acc = PSEL && PENABLE;
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; acc; endsequence
  property p_ready; s_setup ##1 s_access |-> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("access not ready");
  property p_rd_hold; !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; acc && !mapped |-> PSLVERR && (PWRITE || PRDATA == 32'h0); endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on hole");
  property p_mapped; acc && mapped |-> !PSLVERR; endproperty
  a_mapped: assert property (p_mapped) else $error("error on register");
  property p_oe_idle; CE_N && $past(CE_N) |-> IO_OE == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("driving while idle");
  property p_oe_kind; IO_OE inside {4'h0, 4'h2, 4'hf}; endproperty
  a_oe_kind: assert property (p_oe_kind) else $error("bad enable set");
  property p_oe_hold; !CE_N && IO_OE != 4'h0 |=> CE_N || $stable(IO_OE); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("read stopped early");
  // Write cycle can only end a full cycle time after a frame closed
  property p_boot_late; !$stable(boot_w) |-> $past(CE_N, WRITE_CYCLES + 2); endproperty
  a_boot_late: assert property (p_boot_late) else $error("boot word too early");
endmodule
bind abr_top abr_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_abr_checker (
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CE_N(CE_N), .IO_OE(IO_OE),
  .BOOT_START_ADDR(BOOT_START_ADDR), .BOOT_START_DELAY(BOOT_START_DELAY),
  .BOOT_FEATURE_ENABLE(BOOT_FEATURE_ENABLE));

//--- test/test_autoboot_register_access.sv
module test_autoboot_register_access;
  import abr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WC = 40;
  logic CLK = 1'b0, RESET = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, w, d, exp_boot;
  logic PREADY, PSLVERR, SCK, CE_N, e, BOOT_FEATURE_ENABLE;
  logic [3:0] IO_IN, IO_OUT, IO_OE, BOOT_START_DELAY;
  logic [23:0] BOOT_START_ADDR;
  logic [63:0] g;
  int n_fail = 0, samples_checked = 0, cycles = 0, nb, st;
  integer seed = 32'h49fe;
  abr_top #(.WRITE_CYCLES(WC)) u_abr_top (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SCK(SCK), .CE_N(CE_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
    .BOOT_START_ADDR(BOOT_START_ADDR), .BOOT_START_DELAY(BOOT_START_DELAY),
    .BOOT_FEATURE_ENABLE(BOOT_FEATURE_ENABLE));
  abr_host u_abr_host (.sck(SCK), .ce_n(CE_N), .io_in(IO_IN), .io_out(IO_OUT));
  always #2.5 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] swap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Waits until PREADY is high; the bench timeout ends a hang
    do @(posedge CLK); while (PREADY !== 1'b1);
    d = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic link(input bit q, input logic [7:0] op, input int n);
    u_abr_host.frame(q, op, w, n, g);
    repeat (8) @(posedge CLK);
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    // A real rising edge, so the link-clock toggles are cleared too
    RESET <= 1'b1;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    repeat (6) @(posedge CLK);
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, 12'(4 * a), 32'h0);
      chk({e, d}, 64'h0);
    end
    apb(1'b1, ABR_OFS_BOOT, 32'h5a5a_a5a5);
    apb(1'b0, 12'h00c, 32'h0);
    chk({e, d}, {1'b1, 32'h0});
    exp_boot = 32'h0;
    for (int q = 0; q < 2; q++) begin
      st = q ? 4 : 1;
      apb(1'b1, ABR_OFS_CTRL, {30'h0, q[0], q[0]});
      // Try 0 has no enable, tries 1 and 2 are one unit short and long
      for (int k = 0; k < 4; k++) begin
        w = $random(seed);
        nb = k == 1 ? 32 - st : k == 2 ? 32 + st : 32;
        if (k > 0)
          link(q[0], ABR_OP_WRITE_ENABLE, 0);
        link(q[0], ABR_OP_BOOT_WRITE, nb);
        apb(1'b0, ABR_OFS_STATUS, 32'h0);
        chk(d, {25'h0, q[0], 4'h0, k > 0, k == 3});
        link(q[0], ABR_OP_STATUS_READ, 8);
        chk(g[7:0], {1'b0, q[0], 4'h0, k > 0, k == 3});
        if (k == 3)
          exp_boot = w;
        repeat (WC) @(posedge CLK);
        apb(1'b0, ABR_OFS_STATUS, 32'h0);
        chk(d, {25'h0, q[0], 4'h0, k == 1 || k == 2, 1'b0});
        apb(1'b0, ABR_OFS_BOOT, 32'h0);
        chk(d, exp_boot);
        chk({BOOT_START_ADDR, BOOT_START_DELAY, BOOT_FEATURE_ENABLE},
            {exp_boot[31:8], exp_boot[4:1], exp_boot[0]});
      end
      w = $random(seed);
      link(q[0], ABR_OP_BOOT_READ, 64);
      chk(g, {swap(exp_boot), swap(exp_boot)});
    end
    tally_and_finish();
  end
endmodule
